//--- spp_pkg.sv
/*
 package for the sram page pointer register bank: offsets, field layout, reset values,
 page encoding and the access-kind encoding shared by the bank and its core-facing side.
 assumes a 32-bit axi4-lite slave; printed offsets 0x0d1, 0x0d3 and 0x0d5 are not multiples of four, so they are
 register indices and the byte address is four times the index.
*/
package spp_pkg;
    localparam int unsigned SPP_ADDR_W = 12;
    localparam int unsigned SPP_PAGE_W = 3;
    localparam int unsigned SPP_REG_W = 8;
    // register indices as printed
    localparam logic [9:0] SPP_IDX_STACK = 10'h0d1;
    localparam logic [9:0] SPP_IDX_INDEXED = 10'h0d3;
    localparam logic [9:0] SPP_IDX_IND_RD = 10'h0d4;
    localparam logic [9:0] SPP_IDX_IND_WR = 10'h0d5;
    localparam logic [SPP_PAGE_W-1:0] SPP_PAGE_RST = 3'h0;
    localparam int unsigned SPP_PAGE_LSB = 0;
    localparam int unsigned SPP_NUM_PAGES_MAX = 8;
    localparam logic [1:0] SPP_RESP_OKAY = 2'h0;
    localparam logic [1:0] SPP_RESP_SLVERR = 2'h2;
    // kind of memory access presented by the core
    typedef enum logic [2:0] {
        SPP_ACC_NORMAL = 3'h0,
        SPP_ACC_STACK = 3'h1,
        SPP_ACC_INDEXED = 3'h2,
        SPP_ACC_IND_RD = 3'h3,
        SPP_ACC_IND_WR = 3'h4
    } spp_acc_t;
endpackage : spp_pkg

//--- spp_page_if.sv
/*
 interface carrying the four page pointers from the register bank to the page selector.
 assumes both ends share aclk.
*/
`timescale 1ns/1ns
`default_nettype none
interface spp_page_if;
    import spp_pkg::*;
    logic [SPP_PAGE_W-1:0] stack_page;
    logic [SPP_PAGE_W-1:0] indexed_page;
    logic [SPP_PAGE_W-1:0] ind_rd_page;
    logic [SPP_PAGE_W-1:0] ind_wr_page;
    modport bank (output stack_page, indexed_page, ind_rd_page, ind_wr_page);
    modport sel (input stack_page, indexed_page, ind_rd_page, ind_wr_page);
endinterface : spp_page_if
`default_nettype wire

//--- spp_page_sel.sv
/*
 page selector: picks the page for the access kind the core presents.
 assumes the access kind and normal page are synchronous to aclk.
*/
`timescale 1ns/1ns
`default_nettype none
module spp_page_sel
    import spp_pkg::*;
(
    // pointers
    spp_page_if.sel pages,
    // core side
    input wire spp_acc_t acc_kind,
    input wire logic [SPP_PAGE_W-1:0] normal_page,
    input wire logic multi_page,
    output logic [SPP_PAGE_W-1:0] sel_page
);
    logic [SPP_PAGE_W-1:0] kind_page;
    // page value passes through unchanged: binary page number
    always_comb begin
        unique case (acc_kind)
            SPP_ACC_STACK: kind_page = pages.stack_page;
            SPP_ACC_INDEXED: kind_page = pages.indexed_page;
            SPP_ACC_IND_RD: kind_page = pages.ind_rd_page;
            SPP_ACC_IND_WR: kind_page = pages.ind_wr_page;
            default: kind_page = normal_page;
        endcase
    end
    // single-page parts always address page 0
    assign sel_page = multi_page ? kind_page : SPP_PAGE_RST;
endmodule : spp_page_sel
`default_nettype wire

//--- spp_regs.sv
/*
 sram page pointer register bank behind an axi4-lite slave, plus the page
 selection handed to the core's addressing logic.
 assumes a single aclk domain and a master that keeps axi4-lite handshakes.
*/
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module spp_regs
    import spp_pkg::*;
#(
    parameter int unsigned NUM_PAGES = SPP_NUM_PAGES_MAX
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address
    input wire logic [SPP_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address
    input wire logic [SPP_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // core addressing
    input wire spp_acc_t acc_kind,
    input wire logic [SPP_PAGE_W-1:0] normal_page,
    output logic [SPP_PAGE_W-1:0] acc_page
);
    // refused at elaboration: a page field of three bits cannot name more than eight pages
    if (NUM_PAGES < 1 || NUM_PAGES > SPP_NUM_PAGES_MAX) begin : g_bad_pages
        $error("NUM_PAGES must be 1 to 8");
    end

    localparam logic MULTI_PAGE = (NUM_PAGES > 1);

    ////////////////////////////////////////////////////////////////////////////
    // write channel: address and data latched independently, in either order
    logic aw_held_q, aw_held_d;
    logic w_held_q, w_held_d;
    logic [SPP_ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [SPP_PAGE_W-1:0] wpage_q, wpage_d;
    logic wlane0_q, wlane0_d;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic aw_fire, w_fire, do_write;
    logic [SPP_PAGE_W-1:0] stack_q, indexed_q, ind_rd_q, ind_wr_q;

    assign aw_fire = s_axi_awvalid && !aw_held_q && !bvalid_q;
    assign w_fire = s_axi_wvalid && !w_held_q && !bvalid_q;
    assign aw_held_d = aw_held_q ? !do_write : aw_fire;
    assign w_held_d = w_held_q ? !do_write : w_fire;
    assign awaddr_d = aw_fire ? s_axi_awaddr : awaddr_q;
    assign wpage_d = w_fire ? s_axi_wdata[SPP_PAGE_LSB +: SPP_PAGE_W] : wpage_q;
    assign wlane0_d = w_fire ? s_axi_wstrb[0] : wlane0_q;
    assign do_write = aw_held_q && w_held_q && !bvalid_q;

    // decode: byte address is four times the printed index
    logic [9:0] widx;
    logic w_low_ok;
    logic hit_stack_w, hit_indexed_w, hit_ind_rd_w, hit_ind_wr_w, hit_any_w;
    assign widx = awaddr_q[SPP_ADDR_W-1:2];
    assign w_low_ok = (awaddr_q[1:0] == 2'h0);
    assign hit_stack_w = w_low_ok && (widx == SPP_IDX_STACK);
    assign hit_indexed_w = w_low_ok && (widx == SPP_IDX_INDEXED);
    assign hit_ind_rd_w = w_low_ok && (widx == SPP_IDX_IND_RD);
    assign hit_ind_wr_w = w_low_ok && (widx == SPP_IDX_IND_WR);
    assign hit_any_w = hit_stack_w || hit_indexed_w || hit_ind_rd_w || hit_ind_wr_w;

    // reserved bits 7:3 are expected zero from firmware and are simply not stored
    logic wr_en;
    assign wr_en = do_write && wlane0_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wpage_q <= SPP_PAGE_RST;
            wlane0_q <= 1'b0;
        end else begin
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            awaddr_q <= awaddr_d;
            wpage_q <= wpage_d;
            wlane0_q <= wlane0_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stack_q <= SPP_PAGE_RST;
            indexed_q <= SPP_PAGE_RST;
            ind_rd_q <= SPP_PAGE_RST;
            ind_wr_q <= SPP_PAGE_RST;
        end else if (wr_en) begin
            if (hit_stack_w) stack_q <= wpage_q;
            if (hit_indexed_w) indexed_q <= wpage_q;
            if (hit_ind_rd_w) ind_rd_q <= wpage_q;
            if (hit_ind_wr_w) ind_wr_q <= wpage_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= SPP_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= hit_any_w ? SPP_RESP_OKAY : SPP_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ready flops follow the next held state, so they equal !held && !bvalid every cycle
    logic aw_rdy_q, w_rdy_q, bvalid_d;
    assign bvalid_d = do_write || (bvalid_q && !s_axi_bready);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_rdy_q <= 1'b1;
            w_rdy_q <= 1'b1;
        end else begin
            aw_rdy_q <= !aw_held_d && !bvalid_d;
            w_rdy_q <= !w_held_d && !bvalid_d;
        end
    end
    assign s_axi_awready = aw_rdy_q;
    assign s_axi_wready = w_rdy_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    ////////////////////////////////////////////////////////////////////////////
    // read channel: one cycle from address accept to data
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic ar_fire;
    logic [9:0] ridx;
    logic r_low_ok, hit_any_r;
    logic [SPP_PAGE_W-1:0] rpage;
    assign ar_fire = s_axi_arvalid && !rvalid_q;
    assign ridx = s_axi_araddr[SPP_ADDR_W-1:2];
    assign r_low_ok = (s_axi_araddr[1:0] == 2'h0);
    assign rpage = !r_low_ok ? SPP_PAGE_RST :
                   (ridx == SPP_IDX_STACK) ? stack_q :
                   (ridx == SPP_IDX_INDEXED) ? indexed_q :
                   (ridx == SPP_IDX_IND_RD) ? ind_rd_q :
                   (ridx == SPP_IDX_IND_WR) ? ind_wr_q : SPP_PAGE_RST;
    assign hit_any_r = r_low_ok && ((ridx == SPP_IDX_STACK) || (ridx == SPP_IDX_INDEXED) ||
                       (ridx == SPP_IDX_IND_RD) || (ridx == SPP_IDX_IND_WR));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q <= SPP_RESP_OKAY;
            rdata_q <= '0;
        end else if (ar_fire) begin
            rvalid_q <= 1'b1;
            rresp_q <= hit_any_r ? SPP_RESP_OKAY : SPP_RESP_SLVERR;
            rdata_q <= {29'h0, rpage};
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    logic ar_rdy_q, rvalid_d;
    assign rvalid_d = ar_fire || (rvalid_q && !s_axi_rready);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_rdy_q <= 1'b1;
        end else begin
            ar_rdy_q <= !rvalid_d;
        end
    end
    assign s_axi_arready = ar_rdy_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // page selection toward the core, registered for a clean output
    spp_page_if pg ();
    assign pg.stack_page = stack_q;
    assign pg.indexed_page = indexed_q;
    assign pg.ind_rd_page = ind_rd_q;
    assign pg.ind_wr_page = ind_wr_q;

    logic [SPP_PAGE_W-1:0] sel_page;
    logic [SPP_PAGE_W-1:0] acc_page_q;
    spp_page_sel u_sel (
        .pages(pg.sel),
        .acc_kind(acc_kind),
        .normal_page(normal_page),
        .multi_page(MULTI_PAGE),
        .sel_page(sel_page)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_page_q <= SPP_PAGE_RST;
        end else begin
            acc_page_q <= sel_page;
        end
    end
    assign acc_page = acc_page_q;

    // awprot and arprot carry no meaning here
    logic unused_prot;
    assign unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_wdata[31:SPP_PAGE_W], s_axi_wstrb[3:1]};
endmodule : spp_regs
`default_nettype wire

//--- spp_regs_sva.sv
/* checker for spp_regs: axi handshakes, read answers and the page output.
   assumes it is bound into every spp_regs instance. */
`timescale 1ns/1ns
`default_nettype none
module spp_regs_sva
    import spp_pkg::*;
#(
    parameter int unsigned NUM_PAGES = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [SPP_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    // core side
    input wire spp_acc_t acc_kind,
    input wire logic [SPP_PAGE_W-1:0] normal_page,
    input wire logic [SPP_PAGE_W-1:0] acc_page
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire logic ar_map;
    assign ar_map = s_axi_araddr inside {{SPP_IDX_STACK, 2'h0}, {SPP_IDX_INDEXED, 2'h0},
        {SPP_IDX_IND_RD, 2'h0}, {SPP_IDX_IND_WR, 2'h0}};
    sequence s_ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_read_answer: assert property (s_ar_take |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before rready");
    a_read_unmapped: assert property (s_ar_take and !ar_map |=> s_axi_rresp == SPP_RESP_SLVERR && !s_axi_rdata)
        else $error("unmapped read not refused");
    a_read_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:3] == 29'h0)
        else $error("reserved read bits set");
    a_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read taken");
    a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_normal_pass: assert property (NUM_PAGES > 1 && acc_kind == SPP_ACC_NORMAL |=> acc_page == $past(normal_page))
        else $error("normal page not passed");
    a_single_page: assert property (NUM_PAGES == 1 |-> acc_page == 3'h0)
        else $error("page steered on single-page part");
endmodule : spp_regs_sva
bind spp_regs spp_regs_sva #(.NUM_PAGES(NUM_PAGES)) u_spp_regs_sva (.*);
`default_nettype wire

//--- spp_core_model.sv
/* core-side model: presents access kind and normal page each cycle.
   assumes bench requests change just after a rising edge. */
`timescale 1ns/1ns
`default_nettype none
module spp_core_model
    import spp_pkg::*;
(
    // clock
    input wire logic aclk,
    // bench request
    input wire spp_acc_t req_kind,
    input wire logic [SPP_PAGE_W-1:0] req_page,
    // to spp_regs
    output var spp_acc_t acc_kind = SPP_ACC_NORMAL,
    output var logic [SPP_PAGE_W-1:0] normal_page = 3'h0
);
    // a pipeline stage like the core's, so the page answer lags one more cycle
    always @(posedge aclk) begin
        acc_kind <= req_kind;
        normal_page <= req_page;
    end
endmodule : spp_core_model
`default_nettype wire

//--- test_sram_page_pointer_regs.sv
/* bench for spp_regs: axi4-lite register access and page choice per access kind.
   assumes spp_pkg, spp_core_model and the bound checker are compiled before it. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %0t: %h not %h", $time, g, e); end end
module test_sram_page_pointer_regs;
    import spp_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    spp_acc_t acc_kind, req_kind = SPP_ACC_NORMAL;
    logic [2:0] normal_page, acc_page, one_page, req_page = 3'h0;
    int bad_count = 0, tests_run = 0, i;
    logic [11:0] adr [4] = '{{SPP_IDX_STACK, 2'h0}, {SPP_IDX_INDEXED, 2'h0}, {SPP_IDX_IND_RD, 2'h0},
        {SPP_IDX_IND_WR, 2'h0}};
    spp_acc_t knd [4] = '{SPP_ACC_STACK, SPP_ACC_INDEXED, SPP_ACC_IND_RD, SPP_ACC_IND_WR};
    spp_regs u_spp_regs (.*);
    // single-page part shares the bus; only its page output is watched
    spp_regs #(.NUM_PAGES(1)) u_spp_regs_1 (.*, .s_axi_awready(), .s_axi_wready(), .s_axi_bresp(),
        .s_axi_bvalid(), .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .acc_page(one_page));
    spp_core_model u_spp_core_model (.*);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("mismatches %0d, checks %0d", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test
    task automatic tmo;
        bad_count++;
        $display("ERROR %0t: timeout", $time);
        finish_test();
    endtask : tmo
    // bready rises only once the response is seen, so a stalled response is exercised
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge aclk);
            if (s_axi_bvalid && s_axi_bready) break;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (!s_axi_awvalid && !s_axi_wvalid && s_axi_bvalid) s_axi_bready <= 1'b1;
        end
        s_axi_bready <= 1'b0;
        if (n == 20) tmo();
        `CHK(s_axi_bresp, r)
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge aclk);
            if (s_axi_rvalid && s_axi_rready) break;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (!s_axi_arvalid && s_axi_rvalid) s_axi_rready <= 1'b1;
        end
        s_axi_rready <= 1'b0;
        if (n == 20) tmo();
        `CHK(s_axi_rdata, d)
        `CHK(s_axi_rresp, r)
    endtask : rd
    task automatic pg(input spp_acc_t k, input logic [2:0] p, input logic [2:0] e);
        req_kind <= k;
        req_page <= p;
        repeat (3) @(posedge aclk);
        `CHK(acc_page, e)
        `CHK(one_page, 3'h0)
    endtask : pg
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2 aclk = ~aclk;
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (i = 0; i < 4; i++) rd(adr[i], 32'h0, SPP_RESP_OKAY);
        for (i = 0; i < 8; i++) begin
            wr(adr[0], 32'(i), SPP_RESP_OKAY);
            pg(SPP_ACC_STACK, 3'(~i), 3'(i));
        end
        for (i = 0; i < 4; i++) wr(adr[i], 32'(i + 3), SPP_RESP_OKAY);
        for (i = 0; i < 4; i++) pg(knd[i], 3'h1, 3'(i + 3));
        pg(SPP_ACC_NORMAL, 3'h2, 3'h2);
        pg(spp_acc_t'(3'h5), 3'h7, 3'h7);
        s_axi_wstrb <= 4'he;
        wr(adr[0], 32'h1, SPP_RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        wr(12'h348, 32'h1, SPP_RESP_SLVERR);
        wr(12'h345, 32'h1, SPP_RESP_SLVERR);
        rd(12'h348, 32'h0, SPP_RESP_SLVERR);
        for (i = 0; i < 4; i++) rd(adr[i], 32'(i + 3), SPP_RESP_OKAY);
        finish_test();
    end
endmodule : test_sram_page_pointer_regs
`default_nettype wire
